// ### logic/dcc_top.sv
// Overview of operation
// - A capture copies the whole 16-bit timer into the set's capture value.
// - Set one mode sits in control bits 3:0, set two in bits 7:4.
// - Each capture sets the set's flag: flag bit 2 for set one, bit 3 for two.
// - Hardware never clears an event flag; software clears it by writing.
// - A new capture simply overwrites an unread captured value.
// - Codes 0100 falling, 0101 rising, 0110 every 4th, 0111 every 16th rising edge.
// - Mode 00xx turns the set off and clears its prescaler, capture value and output latch.
// - Prescaler counter clears when off, outside capture modes, and on reset.
// - Switching prescaler settings keeps the counter and may raise the flag.
// - In compare mode the compare value is matched against the timer continuously.
// - 1000 sets, 1001 clears, 1010 toggles the output on match and flags; 1011 reserved.
// - Codes 11xx set the flag on match and leave the pin alone; 1111 also triggers.
// - Code 1111 flags and pulses the conversion trigger; timer not reset.
// - The conversion trigger never sets the timer overflow flag (bit 0).
// - Leaving off forces the output latch default: 0, or 1 for clear-on-match.
// - Capture edges follow the pin level even when the pin is an output.
module dcc_top
   import dcc_pkg::*;
(
   input  wire logic        clk_sys,           // System (instruction) clock, 50 MHz
   input  wire logic        rst,               // Synchronous reset, active high
   input  wire logic [4:0]  avs_address,       // Avalon-MM byte address
   input  wire logic        avs_read,          // Avalon-MM read request
   input  wire logic        avs_write,         // Avalon-MM write request
   input  wire logic [31:0] avs_writedata,     // Avalon-MM write data
   input  wire logic [3:0]  avs_byteenable,    // Avalon-MM byte lanes
   output logic      [31:0] avs_readdata,      // Avalon-MM read data
   output logic             avs_waitrequest,   // Avalon-MM wait, high stalls master
   input  wire logic        capture_input_pin, // External event signal
   output logic             compare_out_one,   // Set one compare output latch
   output logic             compare_drive_one, // Set one owns its pin in this mode
   output logic             compare_out_two,   // Set two compare output latch
   output logic             compare_drive_two, // Set two owns its pin in this mode
   output logic             conv_trigger       // One-cycle conversion start pulse
);

   dcc_set_if set_one ();
   dcc_set_if set_two ();

   dcc_bus_state_t bus_state_r, bus_state_nxt;
   logic [31:0]    rdata_r,     rdata_nxt;
   logic [31:0]    rd_word;
   logic           wr_go;

   logic [7:0]     mode_r,      mode_nxt;
   logic           run_r,       run_nxt;
   logic [15:0]    timer_r,     timer_nxt;
   logic [15:0]    cmp_one_r,   cmp_one_nxt;
   logic [15:0]    cmp_two_r,   cmp_two_nxt;
   logic           ovf_flag_r,  ovf_flag_nxt;
   logic [1:0]     evt_flag_r,  evt_flag_nxt;
   logic           trig_r,      trig_nxt;
   logic [31:0]    merged;
   logic [7:0]     clr_mask;
   logic           ovf_set;

   logic           pin_s1_r,    pin_s2_r,    pin_prev_r;
   logic           rise,        fall;

   // Bus: every access waits exactly one cycle
   always_comb begin
      bus_state_nxt = bus_state_r;
      rdata_nxt     = rdata_r;
      case (bus_state_r)
         BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_state_nxt = BUS_ANSWER;
               rdata_nxt     = rd_word;
            end
         end
         BUS_ANSWER: begin
            bus_state_nxt = BUS_IDLE;
         end
         default: begin
            bus_state_nxt = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_state_r <= BUS_IDLE;
         rdata_r     <= 32'h0000_0000;
      end else begin
         bus_state_r <= bus_state_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && (bus_state_r == BUS_IDLE);
   assign wr_go           = avs_write && (bus_state_r == BUS_ANSWER);
   assign avs_readdata    = rdata_r;

   // Read map, unmapped addresses read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (avs_address == OFS_MODE) begin
         rd_word[7:0] = mode_r;
      end else if (avs_address == OFS_FLAG) begin
         rd_word[FLG_OVF]     = ovf_flag_r;
         rd_word[FLG_SET_ONE] = evt_flag_r[0];
         rd_word[FLG_SET_TWO] = evt_flag_r[1];
      end else if (avs_address == OFS_TIMER) begin
         rd_word[15:0] = timer_r;
      end else if (avs_address == OFS_TCTL) begin
         rd_word[TCTL_RUN] = run_r;
      end else if (avs_address == OFS_CMP1) begin
         rd_word[15:0] = cmp_one_r;
      end else if (avs_address == OFS_CAP1) begin
         rd_word[15:0] = set_one.capture;
      end else if (avs_address == OFS_CMP2) begin
         rd_word[15:0] = cmp_two_r;
      end else if (avs_address == OFS_CAP2) begin
         rd_word[15:0] = set_two.capture;
      end
   end

   // Registers, timer and flags
   always_comb begin
      merged       = be_merge(rd_word, avs_writedata, avs_byteenable);
      mode_nxt     = mode_r;
      run_nxt      = run_r;
      cmp_one_nxt  = cmp_one_r;
      cmp_two_nxt  = cmp_two_r;
      clr_mask     = 8'h00;
      timer_nxt    = run_r ? timer_r + 16'h0001 : timer_r;
      ovf_set      = run_r && (timer_r == 16'hffff);

      if (wr_go && (avs_address == OFS_MODE)) begin
         mode_nxt = merged[7:0];
      end else if (wr_go && (avs_address == OFS_TCTL)) begin
         run_nxt = merged[TCTL_RUN];
      end else if (wr_go && (avs_address == OFS_TIMER)) begin
         timer_nxt = merged[15:0];
         ovf_set   = 1'b0;
      end else if (wr_go && (avs_address == OFS_CMP1)) begin
         cmp_one_nxt = merged[15:0];
      end else if (wr_go && (avs_address == OFS_CMP2)) begin
         cmp_two_nxt = merged[15:0];
      end else if (wr_go && (avs_address == OFS_FLAG) && avs_byteenable[0]) begin
         clr_mask = avs_writedata[7:0];
      end

      // A flag set in the same cycle as its clear stays set
      ovf_flag_nxt    = (ovf_flag_r    && !clr_mask[FLG_OVF])     || ovf_set;
      evt_flag_nxt[0] = (evt_flag_r[0] && !clr_mask[FLG_SET_ONE]) || set_one.event_p;
      evt_flag_nxt[1] = (evt_flag_r[1] && !clr_mask[FLG_SET_TWO]) || set_two.event_p;
      trig_nxt        = set_one.trigger_p || set_two.trigger_p;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_r     <= RST_MODE;
         run_r      <= RST_RUN;
         timer_r    <= RST_TIMER;
         cmp_one_r  <= RST_CMP;
         cmp_two_r  <= RST_CMP;
         ovf_flag_r <= 1'b0;
         evt_flag_r <= 2'b00;
         trig_r     <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         run_r      <= run_nxt;
         timer_r    <= timer_nxt;
         cmp_one_r  <= cmp_one_nxt;
         cmp_two_r  <= cmp_two_nxt;
         ovf_flag_r <= ovf_flag_nxt;
         evt_flag_r <= evt_flag_nxt;
         trig_r     <= trig_nxt;
      end
   end

   // Pin synchroniser; edges are taken from the pin level whatever its direction
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1_r   <= 1'b0;
         pin_s2_r   <= 1'b0;
         pin_prev_r <= 1'b0;
      end else begin
         pin_s1_r   <= capture_input_pin;
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   assign rise = pin_s2_r && !pin_prev_r;
   assign fall = !pin_s2_r && pin_prev_r;

   assign set_one.mode      = mode_r[FLD_ONE_MODE_LSB +: 4];
   assign set_two.mode      = mode_r[FLD_TWO_MODE_LSB +: 4];
   assign set_one.timer     = timer_r;
   assign set_two.timer     = timer_r;
   assign set_one.cmp_value = cmp_one_r;
   assign set_two.cmp_value = cmp_two_r;
   assign set_one.rise      = rise;
   assign set_two.rise      = rise;
   assign set_one.fall      = fall;
   assign set_two.fall      = fall;

   dcc_capcmp_set u_set_one (
      .clk_sys (clk_sys),
      .rst     (rst),
      .s       (set_one)
   );

   dcc_capcmp_set u_set_two (
      .clk_sys (clk_sys),
      .rst     (rst),
      .s       (set_two)
   );

   assign compare_out_one   = set_one.cmp_level;
   assign compare_drive_one = set_one.cmp_drive;
   assign compare_out_two   = set_two.cmp_level;
   assign compare_drive_two = set_two.cmp_drive;
   assign conv_trigger      = trig_r;

endmodule : dcc_top

// ### logic/dcc_pkg.sv
package dcc_pkg;

   localparam int unsigned TMR_W            = 16;
   localparam int unsigned ADDR_W           = 5;

   localparam logic [4:0]  OFS_MODE         = 5'h00;
   localparam logic [4:0]  OFS_FLAG         = 5'h04;
   localparam logic [4:0]  OFS_TIMER        = 5'h08;
   localparam logic [4:0]  OFS_TCTL         = 5'h0c;
   localparam logic [4:0]  OFS_CMP1         = 5'h10;
   localparam logic [4:0]  OFS_CAP1         = 5'h14;
   localparam logic [4:0]  OFS_CMP2         = 5'h18;
   localparam logic [4:0]  OFS_CAP2         = 5'h1c;

   localparam int          FLD_ONE_MODE_LSB = 0;
   localparam int          FLD_TWO_MODE_LSB = 4;
   localparam int          FLG_OVF          = 0;
   localparam int          FLG_SET_ONE      = 2;
   localparam int          FLG_SET_TWO      = 3;
   localparam int          TCTL_RUN         = 0;

   localparam logic [7:0]  RST_MODE         = 8'h00;
   localparam logic        RST_RUN          = 1'h1;
   localparam logic [15:0] RST_TIMER        = 16'h0000;
   localparam logic [15:0] RST_CMP          = 16'h0000;

   localparam logic [3:0]  MODE_CAP_FALL    = 4'h4;
   localparam logic [3:0]  MODE_CAP_RISE    = 4'h5;
   localparam logic [3:0]  MODE_CAP_DIV4    = 4'h6;
   localparam logic [3:0]  MODE_CAP_DIV16   = 4'h7;
   localparam logic [3:0]  MODE_CMP_SET     = 4'h8;
   localparam logic [3:0]  MODE_CMP_CLR     = 4'h9;
   localparam logic [3:0]  MODE_CMP_TGL     = 4'ha;
   localparam logic [3:0]  MODE_CMP_RSVD    = 4'hb;
   localparam logic [3:0]  MODE_CMP_TRIG    = 4'hf;

   localparam logic [1:0]  PRESC_DIV4_LAST  = 2'h3;
   localparam logic [3:0]  PRESC_DIV16_LAST = 4'hf;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_ANSWER = 2'b01
   } dcc_bus_state_t;

   function automatic logic mode_is_off(input logic [3:0] m);
      return m[3:2] == 2'b00;
   endfunction : mode_is_off

   function automatic logic mode_is_capture(input logic [3:0] m);
      return m[3:2] == 2'b01;
   endfunction : mode_is_capture

   function automatic logic mode_drives_pin(input logic [3:0] m);
      return (m == MODE_CMP_SET) || (m == MODE_CMP_CLR) || (m == MODE_CMP_TGL);
   endfunction : mode_drives_pin

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

endpackage : dcc_pkg

// ### logic/dcc_set_if.sv
interface dcc_set_if;
   logic [3:0]  mode;
   logic [15:0] timer;
   logic [15:0] cmp_value;
   logic        rise;
   logic        fall;
   logic        event_p;
   logic [15:0] capture;
   logic        cmp_level;
   logic        cmp_drive;
   logic        trigger_p;

   modport ctrl (output mode, timer, cmp_value, rise, fall,
                 input  event_p, capture, cmp_level, cmp_drive, trigger_p);
   modport unit (input  mode, timer, cmp_value, rise, fall,
                 output event_p, capture, cmp_level, cmp_drive, trigger_p);
endinterface : dcc_set_if

// ### logic/dcc_capcmp_set.sv
module dcc_capcmp_set
   import dcc_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst,     // Synchronous reset, active high
   dcc_set_if.unit  s        // Mode, timer and results of one set
);

   logic [3:0]  presc_r,     presc_nxt;
   logic [15:0] cap_r,       cap_nxt;
   logic        lvl_r,       lvl_nxt;
   logic [3:0]  mode_prev_r, mode_prev_nxt;
   logic        match_prev_r, match_prev_nxt;
   logic        evt_r,       evt_nxt;
   logic        trig_r,      trig_nxt;
   logic        fire;
   logic        hit;
   logic        entered;

   always_comb begin
      fire = 1'b0;
      case (s.mode)
         MODE_CAP_FALL:  fire = s.fall;
         MODE_CAP_RISE:  fire = s.rise;
         MODE_CAP_DIV4:  fire = s.rise && (presc_r[1:0] == PRESC_DIV4_LAST);
         MODE_CAP_DIV16: fire = s.rise && (presc_r == PRESC_DIV16_LAST);
         default:        fire = 1'b0;
      endcase

      // Counter survives a change between prescaler settings
      if (!mode_is_capture(s.mode)) begin
         presc_nxt = 4'h0;
      end else if (s.rise) begin
         presc_nxt = presc_r + 4'h1;
      end else begin
         presc_nxt = presc_r;
      end

      if (mode_is_off(s.mode)) begin
         cap_nxt = 16'h0000;
      end else if (fire) begin
         cap_nxt = s.timer;
      end else begin
         cap_nxt = cap_r;
      end

      match_prev_nxt = (s.timer == s.cmp_value);
      hit            = s.mode[3] && match_prev_nxt && !match_prev_r;
      entered        = (s.mode != mode_prev_r);
      mode_prev_nxt  = s.mode;

      if (mode_is_off(s.mode)) begin
         lvl_nxt = 1'b0;
      end else if (entered && (s.mode == MODE_CMP_CLR)) begin
         lvl_nxt = 1'b1;
      end else if (entered && mode_drives_pin(s.mode)) begin
         lvl_nxt = 1'b0;
      end else if (hit && (s.mode == MODE_CMP_SET)) begin
         lvl_nxt = 1'b1;
      end else if (hit && (s.mode == MODE_CMP_CLR)) begin
         lvl_nxt = 1'b0;
      end else if (hit && (s.mode == MODE_CMP_TGL)) begin
         lvl_nxt = !lvl_r;
      end else begin
         lvl_nxt = lvl_r;
      end

      evt_nxt  = fire || (hit && (s.mode != MODE_CMP_RSVD));
      trig_nxt = hit && (s.mode == MODE_CMP_TRIG);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         presc_r      <= 4'h0;
         cap_r        <= 16'h0000;
         lvl_r        <= 1'b0;
         mode_prev_r  <= 4'h0;
         match_prev_r <= 1'b0;
         evt_r        <= 1'b0;
         trig_r       <= 1'b0;
      end else begin
         presc_r      <= presc_nxt;
         cap_r        <= cap_nxt;
         lvl_r        <= lvl_nxt;
         mode_prev_r  <= mode_prev_nxt;
         match_prev_r <= match_prev_nxt;
         evt_r        <= evt_nxt;
         trig_r       <= trig_nxt;
      end
   end

   assign s.event_p   = evt_r;
   assign s.capture   = cap_r;
   assign s.cmp_level = lvl_r;
   assign s.cmp_drive = mode_drives_pin(s.mode);
   assign s.trigger_p = trig_r;

endmodule : dcc_capcmp_set

// ### verification/dcc_monitor.sv
module dcc_monitor
   import dcc_pkg::*;
(
   input wire logic        clk_sys,           // Clock
   input wire logic        rst,               // Reset
   input wire logic [4:0]  avs_address,       // Address
   input wire logic        avs_read,          // Read
   input wire logic        avs_write,         // Write
   input wire logic [31:0] avs_writedata,     // Write data
   input wire logic [3:0]  avs_byteenable,    // Lanes
   input wire logic [31:0] avs_readdata,      // Read data
   input wire logic        avs_waitrequest,   // Wait
   input wire logic        capture_input_pin, // Event pin
   input wire logic        compare_out_one,   // Latch one
   input wire logic        compare_drive_one, // Drive one
   input wire logic        compare_out_two,   // Latch two
   input wire logic        compare_drive_two, // Drive two
   input wire logic        conv_trigger       // Trigger
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic       acc;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Shadow of the mode register, updated on accepted writes
   assign acc = avs_write & ~avs_waitrequest & (avs_address == OFS_MODE) & avs_byteenable[0];
   always_comb mode_nxt = acc ? avs_writedata[7:0] : mode_r;
   always_ff @(posedge clk_sys) mode_r <= rst ? RST_MODE : mode_nxt;

   wait_one_a: assert property ((avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest)
      else $error("wait longer than one cycle");
   wait_idle_a: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
      else $error("wait without request");
   unmapped_rd_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   drive_one_a: assert property (compare_drive_one == (mode_r[3:0] inside {4'h8, 4'h9, 4'ha}))
      else $error("set one drive wrong");
   drive_two_a: assert property (compare_drive_two == (mode_r[7:4] inside {4'h8, 4'h9, 4'ha}))
      else $error("set two drive wrong");
   off_latch_a: assert property (mode_r[3:2] == 2'h0 && $past(mode_r[3:2]) == 2'h0 |-> !compare_out_one)
      else $error("latch not cleared when off");
   off_latch_two_a: assert property (mode_r[7:6] == 2'h0 && $past(mode_r[7:6]) == 2'h0 |-> !compare_out_two)
      else $error("latch two not cleared when off");
   clr_default_a: assert property (mode_r[3:0] == 4'h9 && $past(mode_r[3:0]) != 4'h9 |-> ##[0:1] compare_out_one)
      else $error("clear mode default not one");
   trig_pulse_a: assert property (conv_trigger |=> !conv_trigger)
      else $error("trigger longer than one cycle");
   trig_mode_a: assert property (conv_trigger |-> $past(mode_r[3:0], 2) == 4'hf || $past(mode_r[7:4], 2) == 4'hf)
      else $error("trigger outside trigger mode");
   pin_hold_a: assert property (mode_r[3:2] == 2'h3 && $past(mode_r[3:0], 2) == mode_r[3:0]
      |-> $stable(compare_out_one))
      else $error("latch moved in flag only mode");
endmodule : dcc_monitor

bind dcc_top dcc_monitor u_mon (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .capture_input_pin, .compare_out_one,
   .compare_drive_one, .compare_out_two, .compare_drive_two, .conv_trigger);

// ### verification/dcc_pin_model.sv
module dcc_pin_model (
   input  wire logic clk_sys,   // Clock
   input  wire logic cmp_out,   // Compare latch
   input  wire logic cmp_drive, // Set owns pin
   output logic      event_pin, // Capture pin
   output logic      cmp_pin    // Resolved pin level
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pull-up holds the pin high while the set does not drive it
   assign cmp_pin = cmp_drive ? cmp_out : 1'b1;

   initial event_pin = 1'b0;

   task automatic edges(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         event_pin <= 1'b1;
         repeat (4) @(posedge clk_sys);
         event_pin <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask : edges
endmodule : dcc_pin_model

// ### verification/dcc_top_tb_top.sv
module dcc_top_tb_top
   import dcc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, capture_input_pin;
   logic        compare_out_one, compare_drive_one, compare_out_two, compare_drive_two;
   logic        conv_trigger, cmp_pin;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, v;
   logic [3:0]  avs_byteenable;
   int          err_count, checks_done, trig_seen, t0;
   logic [3:0]  cm [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
   int          cn [4] = '{1, 1, 4, 16};
   logic [3:0]  km [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf};

   dcc_top DUT (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .capture_input_pin, .compare_out_one, .compare_drive_one,
      .compare_out_two, .compare_drive_two, .conv_trigger);
   dcc_pin_model pin (.clk_sys, .cmp_out(compare_out_one), .cmp_drive(compare_drive_one),
      .event_pin(capture_input_pin), .cmp_pin);

   always #10 clk_sys = ~clk_sys;

   always @(negedge clk_sys) begin
      if (conv_trigger === 1'b1) trig_seen++;
   end

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
   endtask : check

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= ~w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, v);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string n);
      bus(1'b0, a, 32'h0, v);
      check(n, v, exp);
   endtask : rd_chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #400000;
      err_count++;
      end_of_test();
   end

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(OFS_MODE, 32'h0, "mode_reset");
      rd_chk(OFS_TCTL, 32'h1, "run_reset");
      rd_chk(OFS_CAP1, 32'h0, "cap_reset");
      rd_chk(5'h01, 32'h0, "unmapped");
      wr(OFS_MODE, 32'h95);
      rd_chk(OFS_MODE, 32'h95, "mode_rw");
      check("drive_two", 32'(compare_drive_two), 32'h1);
      check("out_two", 32'(compare_out_two), 32'h1);
      $display("register test done");
      foreach (cm[i]) begin
         wr(OFS_MODE, 32'h0);
         wr(OFS_TCTL, 32'h0);
         wr(OFS_TIMER, 32'h1000 + i);
         wr(OFS_FLAG, 32'hd);
         wr(OFS_MODE, {24'h0, cm[i], cm[i]});
         pin.edges(cn[i] - 1);
         rd_chk(OFS_FLAG, 32'h0, "flag_early");
         wr(OFS_TIMER, 32'h2000 + i);
         pin.edges(1);
         rd_chk(OFS_FLAG, 32'hc, "flag_cap");
         rd_chk(OFS_CAP1, 32'h2000 + i, "cap_one");
         rd_chk(OFS_CAP2, 32'h2000 + i, "cap_two");
         $display("capture test %0d done", i);
      end
      wr(OFS_MODE, 32'h0);
      wr(OFS_MODE, 32'h55);
      wr(OFS_TIMER, 32'h3000);
      pin.edges(1);
      wr(OFS_TIMER, 32'h3001);
      pin.edges(1);
      rd_chk(OFS_FLAG, 32'hc, "flag_kept");
      rd_chk(OFS_CAP1, 32'h3001, "cap_over");
      wr(OFS_MODE, 32'h0);
      rd_chk(OFS_CAP1, 32'h0, "cap_off");
      $display("overwrite test done");
      foreach (km[i]) begin
         wr(OFS_MODE, 32'h0);
         wr(OFS_FLAG, 32'hd);
         wr(OFS_TIMER, 32'h0100);
         wr(OFS_CMP1, 32'h0108);
         wr(OFS_MODE, {28'h0, km[i]});
         t0 = trig_seen;
         // Mode lands at the write edge, the latch default one edge later
         repeat (2) @(negedge clk_sys);
         check("pin_default", 32'(cmp_pin), (km[i] == 4'h8 || km[i] == 4'ha) ? 32'h0 : 32'h1);
         wr(OFS_TCTL, 32'h1);
         repeat (20) @(posedge clk_sys);
         wr(OFS_TCTL, 32'h0);
         check("pin_match", 32'(cmp_pin), (km[i] == 4'h9) ? 32'h0 : 32'h1);
         rd_chk(OFS_FLAG, (km[i] == 4'hb) ? 32'h0 : 32'h4, "flag_cmp");
         check("trigger", 32'(trig_seen - t0), (km[i] == 4'hf) ? 32'h1 : 32'h0);
         bus(1'b0, OFS_TIMER, 32'h0, v);
         check("timer_kept", {31'h0, v > 32'h0108}, 32'h1);
         $display("compare test %0d done", i);
      end
      end_of_test();
   end
endmodule : dcc_top_tb_top
